// >>> core/dpe_core.sv
/*
  Dual phasor estimator core: two estimators on one sample stream, APB registers,
  config checking, weighted accumulation and 50 ms batch reporting.
  Assumes samples synchronous to i_clk, 64 samples per nominal cycle.
*/
`timescale 1ns/1ps
module dpe_core #(
  parameter int BATCH_CYCLES = dpe_pkg::BATCH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire dpe_pkg::dpe_smp_s i_smp,
  output dpe_pkg::dpe_rep_s [1:0] o_rep
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  // Estimates per second by rate index, zero marks an illegal index
  localparam logic [6:0] RATE50_T [16] = '{
      7'h01, 7'h02, 7'h05, 7'h0A, 7'h19, 7'h32, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  localparam logic [6:0] RATE60_T [16] = '{
      7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h0A, 7'h0C,
      7'h0F, 7'h14, 7'h1E, 7'h3C, 7'h00, 7'h00, 7'h00, 7'h00};

  function automatic logic [6:0] rate_of(input logic f60, input logic [3:0] idx);
    return f60 ? RATE60_T[idx] : RATE50_T[idx];
  endfunction : rate_of

  function automatic logic is_top(input dpe_pkg::dpe_cfg_s c);
    return c.enable && (c.ridx == (c.freq60 ? dpe_pkg::RIDX_MAX60 : dpe_pkg::RIDX_MAX50));
  endfunction : is_top

  function automatic logic [9:0] load_of(input dpe_pkg::dpe_cfg_s c);
    logic [11:0] p;
    p = 12'(rate_of(c.freq60, c.ridx)) * (12'(c.wlen_m1) + 12'h001);
    return c.enable ? p[9:0] : 10'h000;
  endfunction : load_of

  function automatic logic signed [16:0] cos6(input logic [5:0] a);
    logic [3:0] i;
    logic [4:0] j;
    logic [15:0] t;
    i = a[3:0];
    j = a[4] ? 5'h10 - {1'b0, i} : {1'b0, i};
    unique case (j)
      5'h00: t = 16'h7FFF;
      5'h01: t = 16'h7F62;
      5'h02: t = 16'h7D8A;
      5'h03: t = 16'h7A7D;
      5'h04: t = 16'h7642;
      5'h05: t = 16'h70E3;
      5'h06: t = 16'h6A6E;
      5'h07: t = 16'h62F2;
      5'h08: t = 16'h5A82;
      5'h09: t = 16'h5134;
      5'h0A: t = 16'h471D;
      5'h0B: t = 16'h3C57;
      5'h0C: t = 16'h30FC;
      5'h0D: t = 16'h2528;
      5'h0E: t = 16'h18F9;
      5'h0F: t = 16'h0C8C;
      default: t = 16'h0000;
    endcase
    return (a[5] ^ a[4]) ? -$signed({1'b0, t}) : $signed({1'b0, t});
  endfunction : cos6

  //////////////////////////////////////////////////////////////////////////////
  // APB registers
  dpe_pkg::dpe_cfg_s cfg_q [2];
  logic [15:0] id_q [2];
  logic [31:0] corr_q;
  logic [1:0] rej_q;
  logic [31:0] tag_q [2];
  logic [31:0] prdata_q;
  logic setup, wr, addr_ok;
  logic [1:0] cfg_wr, cfg_ok;

  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  assign addr_ok = (i_paddr <= dpe_pkg::A_CORR) && (i_paddr[1:0] == 2'b00);
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign o_prdata = prdata_q;
  assign cfg_wr[0] = wr && (i_paddr == dpe_pkg::A_CFG0);
  assign cfg_wr[1] = wr && (i_paddr == dpe_pkg::A_CFG1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      unique case (i_paddr)
        dpe_pkg::A_CFG0: prdata_q <= 32'(cfg_q[0]);
        dpe_pkg::A_CFG1: prdata_q <= 32'(cfg_q[1]);
        dpe_pkg::A_STAT: prdata_q <= {22'h00_0000, rej_q, 8'h00};
        dpe_pkg::A_ID0: prdata_q <= {16'h0000, id_q[0]};
        dpe_pkg::A_ID1: prdata_q <= {16'h0000, id_q[1]};
        dpe_pkg::A_TAG0: prdata_q <= tag_q[0];
        dpe_pkg::A_TAG1: prdata_q <= tag_q[1];
        dpe_pkg::A_CORR: prdata_q <= corr_q;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      id_q[0] <= dpe_pkg::ID_RST;
      id_q[1] <= dpe_pkg::ID_RST;
      corr_q <= dpe_pkg::CORR_RST;
    end else if (wr) begin
      if (i_paddr == dpe_pkg::A_ID0) id_q[0] <= i_pwdata[15:0];
      if (i_paddr == dpe_pkg::A_ID1) id_q[1] <= i_pwdata[15:0];
      if (i_paddr == dpe_pkg::A_CORR) corr_q <= i_pwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared corrected samples
  logic signed [17:0] vsum, isum, gsum;
  logic signed [15:0] gain, offs;
  assign gain = $signed(corr_q[31:16]);
  assign offs = $signed(corr_q[15:0]);

  function automatic logic signed [17:0] fix(input logic [15:0] s,
      input logic signed [15:0] g, input logic signed [15:0] o);
    logic signed [31:0] p;
    p = $signed(s) * g;
    return 18'(p >>> 14) + 18'(o);
  endfunction : fix

  assign vsum = fix(i_smp.va, gain, offs) + fix(i_smp.vb, gain, offs)
      + fix(i_smp.vc, gain, offs);
  assign isum = fix(i_smp.ia, gain, offs) + fix(i_smp.ib, gain, offs)
      + fix(i_smp.ic, gain, offs);

  //////////////////////////////////////////////////////////////////////////////
  // Batch tick and microsecond time base
  logic [23:0] bat_cnt_q;
  logic [7:0] us_cnt_q;
  logic [31:0] now_us_q;
  logic tick;
  assign tick = (bat_cnt_q == 24'(BATCH_CYCLES - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bat_cnt_q <= 24'h00_0000;
    end else begin
      bat_cnt_q <= tick ? 24'h00_0000 : bat_cnt_q + 24'h00_0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      us_cnt_q <= 8'h00;
      now_us_q <= 32'h0000_0000;
    end else if (us_cnt_q == 8'(dpe_pkg::US_CYC - 1)) begin
      us_cnt_q <= 8'h00;
      now_us_q <= now_us_q + 32'h0000_0001;
    end else begin
      us_cnt_q <= us_cnt_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Estimators
  for (genvar e = 0; e < 2; e++) begin : g_est
    localparam int O = 1 - e;
    dpe_pkg::dpe_cfg_s cand;
    logic [10:0] tot;
    logic [15:0] ph_q, step;
    logic [9:0] idx_q;
    logic [47:0] acc_q, res_q;
    logic [6:0] racc_q, rsum;
    logic signed [17:0] w, s;
    logic signed [35:0] t1, t2, t3;
    logic signed [16:0] a0, a1, a2, a3;
    logic [1:0] n;
    logic [31:0] gd;
    logic last;

    assign cand = dpe_pkg::dpe_cfg_s'(i_pwdata[21:0]);
    assign tot = {1'b0, load_of(cand)} + {1'b0, load_of(cfg_q[O])};
    assign cfg_ok[e] = !cand.enable || ((rate_of(cand.freq60, cand.ridx) != 7'h00)
        && (cand.win <= dpe_pkg::DPE_W_NUT) && (tot <= {1'b0, dpe_pkg::CYC_BUDGET})
        && !(is_top(cand) && is_top(cfg_q[O])));

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        cfg_q[e] <= '0;
      end else if (cfg_wr[e] && cfg_ok[e]) begin
        cfg_q[e] <= cand;
      end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        rej_q[e] <= 1'b0;
      end else if (cfg_wr[e] && !cfg_ok[e]) begin
        rej_q[e] <= 1'b1;
      end else if (wr && (i_paddr == dpe_pkg::A_STAT) && i_pwdata[dpe_pkg::ST_REJ0 + e]) begin
        rej_q[e] <= 1'b0;
      end
    end

    // Window coefficients, Q15
    always_comb begin
      a0 = 17'sh04000;
      a1 = 17'sh04000;
      a2 = 17'sh00000;
      a3 = 17'sh00000;
      unique case (cfg_q[e].win)
        dpe_pkg::DPE_W_HAMM: begin a0 = 17'sh0451F; a1 = 17'sh03AE1; end
        dpe_pkg::DPE_W_BLACK, dpe_pkg::DPE_W_KAIS: begin
          a0 = 17'sh035C3;
          a2 = 17'sh00A3D;
        end
        dpe_pkg::DPE_W_NUT: begin
          a0 = 17'sh02D8A;
          a1 = 17'sh03E63;
          a2 = 17'sh01276;
          a3 = 17'sh0019D;
        end
        dpe_pkg::DPE_W_FLAT: begin a0 = 17'sh023FA; a1 = 17'sh042AD; a2 = 17'sh01959; end
        dpe_pkg::DPE_W_RECT, dpe_pkg::DPE_W_TRI: begin a0 = 17'sh07FFF; a1 = 17'sh00000; end
        default: begin a0 = 17'sh04000; a1 = 17'sh04000; end
      endcase
    end

    assign t1 = a1 * cos6(ph_q[15:10]);
    assign t2 = a2 * cos6(6'(ph_q[15:10] * 6'h02));
    assign t3 = a3 * cos6(6'(ph_q[15:10] * 6'h03));
    always_comb begin
      if (cfg_q[e].win == dpe_pkg::DPE_W_TRI) begin
        w = ph_q[15] ? 18'(17'h10000 - {1'b0, ph_q}) : 18'({1'b0, ph_q});
      end else begin
        w = 18'(a0) - 18'(t1 >>> 15) + 18'(t2 >>> 15) - 18'(t3 >>> 15);
      end
    end

    // Same shared samples, own group enables
    assign s = (cfg_q[e].volt_en ? vsum : 18'sh00000)
        + (cfg_q[e].curr_en ? isum : 18'sh00000);
    assign step = dpe_pkg::PHASE_NUM / (16'(cfg_q[e].wlen_m1) + 16'h0001);
    assign last = (idx_q == {cfg_q[e].wlen_m1, 6'h3F});

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        ph_q <= 16'h0000;
        idx_q <= 10'h000;
        acc_q <= 48'h0000_0000_0000;
        res_q <= 48'h0000_0000_0000;
      end else if (cfg_wr[e] && cfg_ok[e]) begin
        ph_q <= 16'h0000;
        idx_q <= 10'h000;
        acc_q <= 48'h0000_0000_0000;
      end else if (i_smp.valid && cfg_q[e].enable) begin
        if (last) begin
          res_q <= acc_q + 48'(w * s);
          acc_q <= 48'h0000_0000_0000;
          ph_q <= 16'h0000;
          idx_q <= 10'h000;
        end else begin
          acc_q <= acc_q + 48'(w * s);
          ph_q <= ph_q + step;
          idx_q <= idx_q + 10'h001;
        end
      end
    end

    // Estimates due this batch from rate over 20 batches per second
    assign rsum = racc_q + rate_of(cfg_q[e].freq60, cfg_q[e].ridx);
    always_comb begin
      if (rsum >= 7'(3 * dpe_pkg::BATCH_PER_S)) n = 2'h3;
      else if (rsum >= 7'(2 * dpe_pkg::BATCH_PER_S)) n = 2'h2;
      else if (rsum >= dpe_pkg::BATCH_PER_S) n = 2'h1;
      else n = 2'h0;
    end

    assign gd = 32'(cfg_q[e].freq60 ? dpe_pkg::GD60_US : dpe_pkg::GD50_US)
        * (32'(cfg_q[e].wlen_m1) + 32'h0000_0001);

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        racc_q <= 7'h00;
        o_rep[e] <= '0;
        tag_q[e] <= 32'h0000_0000;
      end else if (tick && cfg_q[e].enable) begin
        racc_q <= rsum - 7'(n) * dpe_pkg::BATCH_PER_S;
        o_rep[e].valid <= (n != 2'h0);
        o_rep[e].count <= n;
        o_rep[e].id <= id_q[e];
        o_rep[e].tag_us <= now_us_q - dpe_pkg::LAT_NEW_US - gd;
        o_rep[e].value <= res_q;
        o_rep[e].float_fmt <= cfg_q[e].float_fmt;
        o_rep[e].groups <= {cfg_q[e].negzero_en, cfg_q[e].pos_en, cfg_q[e].phase_en};
        tag_q[e] <= now_us_q - dpe_pkg::LAT_NEW_US - gd;
      end else begin
        o_rep[e].valid <= 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    a_reject_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_wr[e] && !cfg_ok[e] |=> cfg_q[e] == $past(cfg_q[e]) && rej_q[e])
      else $error("Rejected config changed state");
    a_budget_held: assert property (@(posedge i_clk) disable iff (i_rst)
        11'(load_of(cfg_q[0])) + 11'(load_of(cfg_q[1])) <= 11'(dpe_pkg::CYC_BUDGET))
      else $error("Active configs exceed cycle budget");
    a_single_top: assert property (@(posedge i_clk) disable iff (i_rst)
        !(is_top(cfg_q[0]) && is_top(cfg_q[1])))
      else $error("Both estimators at top rate");
    a_other_untouched: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_wr[e] |=> cfg_q[O] == $past(cfg_q[O]) && $stable(o_rep[O].tag_us) || $past(tick))
      else $error("Other estimator disturbed by config write");
    a_report_on_tick: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rep[e].valid |-> $past(tick) && o_rep[e].count != 2'h0)
      else $error("Report outside batch tick");
    a_disabled_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        !cfg_q[e].enable ##1 !cfg_q[e].enable |-> !o_rep[e].valid)
      else $error("Disabled estimator reported");
    a_rate_count: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rep[e].valid && o_rep[e].count == 2'h3 |-> is_top(cfg_q[e]) || $past(cfg_wr[e]))
      else $error("Three estimates in one batch below top rate");
    a_tag_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rep[e].valid |-> now_us_q - o_rep[e].tag_us >= dpe_pkg::LAT_NEW_US + 32'(dpe_pkg::GD60_US))
      else $error("Tag delay below minimum");
    c_reject: cover property (@(posedge i_clk) cfg_wr[e] && !cfg_ok[e]);
    c_report: cover property (@(posedge i_clk) o_rep[e].valid && o_rep[e].count == 2'h3);
    c_window: cover property (@(posedge i_clk) i_smp.valid && last && cfg_q[e].enable);
  end

  a_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
      tick |=> !tick)
    else $error("Batch tick longer than one cycle");

endmodule : dpe_core

// >>> core/dpe_pkg.sv
/*
  Shared constants, register map and carrier types for the dual phasor estimator.
  Assumes a 200 MHz core clock and an APB master with 32-bit data.
*/
package dpe_pkg;
  localparam int CLK_MHZ = 200;
  localparam int BATCH_MS = 50;
  localparam int BATCH_CYC = BATCH_MS * CLK_MHZ * 1000;
  localparam int US_CYC = CLK_MHZ;
  localparam logic [31:0] LAT_NEW_US = 32'h0000_7530;
  localparam logic [15:0] GD50_US = 16'h2710;
  localparam logic [15:0] GD60_US = 16'h208D;
  localparam logic [9:0] CYC_BUDGET = 10'h190;
  localparam logic [6:0] BATCH_PER_S = 7'h14;
  localparam int SPC_LOG2 = 6;
  localparam logic [15:0] PHASE_NUM = 16'h0400;
  localparam logic [7:0] A_CFG0 = 8'h00;
  localparam logic [7:0] A_CFG1 = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ID0 = 8'h0C;
  localparam logic [7:0] A_ID1 = 8'h10;
  localparam logic [7:0] A_TAG0 = 8'h14;
  localparam logic [7:0] A_TAG1 = 8'h18;
  localparam logic [7:0] A_CORR = 8'h1C;
  localparam int ST_REJ0 = 8;
  localparam int ST_REJ1 = 9;
  localparam logic [31:0] CORR_RST = 32'h4000_0000;
  localparam logic [15:0] ID_RST = 16'h00A5;
  localparam logic [3:0] RIDX_MAX50 = 4'h5;
  localparam logic [3:0] RIDX_MAX60 = 4'hB;

  typedef enum logic [1:0] {DPE_TUNE_OFF, DPE_TUNE_2HZ, DPE_TUNE_5HZ, DPE_TUNE_10HZ} dpe_tune_e;
  typedef enum logic [3:0] {
    DPE_W_RCOS, DPE_W_HANN, DPE_W_HAMM, DPE_W_BLACK, DPE_W_TRI,
    DPE_W_RECT, DPE_W_FLAT, DPE_W_KAIS, DPE_W_NUT
  } dpe_win_e;

  typedef struct packed {
    logic float_fmt;
    logic negzero_en;
    logic pos_en;
    logic phase_en;
    logic curr_en;
    logic volt_en;
    dpe_win_e win;
    logic [3:0] wlen_m1;
    logic [3:0] ridx;
    dpe_tune_e tune;
    logic freq60;
    logic enable;
  } dpe_cfg_s;

  typedef struct packed {
    logic valid;
    logic [15:0] va, vb, vc, ia, ib, ic;
  } dpe_smp_s;

  typedef struct packed {
    logic valid;
    logic [1:0] count;
    logic [15:0] id;
    logic [31:0] tag_us;
    logic [47:0] value;
    logic float_fmt;
    logic [2:0] groups;
  } dpe_rep_s;
endpackage : dpe_pkg

// >>> tb/dpe_partner.sv
/*
  Far-side model: shared three-phase sample source and collector of estimator reports.
  Assumes reports are one-cycle valid pulses on the core clock.
*/
`timescale 1ns/1ps
module dpe_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_flat,
  input wire dpe_pkg::dpe_rep_s [1:0] i_rep,
  output dpe_pkg::dpe_smp_s o_smp,
  output dpe_pkg::dpe_rep_s [1:0] o_last,
  output int o_sum0,
  output int o_sum1,
  output int o_gap
);
  logic [15:0] ramp_q;
  int cyc_q;
  int prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample source, one sample every other clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ramp_q <= 16'h0000;
      cyc_q <= 0;
    end else begin
      cyc_q <= cyc_q + 1;
      if (!i_flat) begin
        ramp_q <= ramp_q + 16'h0137;
      end
    end
  end

  always_comb begin
    o_smp.valid = cyc_q[0];
    o_smp.va = ramp_q;
    o_smp.vb = ramp_q ^ 16'h5555;
    o_smp.vc = ~ramp_q;
    o_smp.ia = ramp_q >> 1;
    o_smp.ib = 16'h0100 - ramp_q;
    o_smp.ic = ramp_q + 16'h0800;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report collector
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_sum0 <= 0;
      o_sum1 <= 0;
    end else begin
      if (i_rep[0].valid === 1'b1) begin
        o_sum0 <= o_sum0 + int'(i_rep[0].count);
        o_gap <= cyc_q - prev_q;
        prev_q <= cyc_q;
      end
      if (i_rep[1].valid === 1'b1) begin
        o_sum1 <= o_sum1 + int'(i_rep[1].count);
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (i_rep[i].valid === 1'b1) begin
        o_last[i] <= i_rep[i];
      end
    end
  end
endmodule : dpe_partner

// >>> tb/dual_phasor_estimator_test.sv
/*
  Self-checking bench for the dual phasor estimator core.
  Assumes an always-ready APB slave and one report tick every BATCH cycles.
*/
`timescale 1ns/1ps
module dual_phasor_estimator_test;
  localparam int BATCH = 200;
  typedef struct {logic [31:0] c0; logic [31:0] c1; int s0; int s1;} dpe_row_s;
  typedef struct {logic [7:0] a; logic [31:0] d; logic ok;} dpe_rej_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clr = 1'b0;
  logic flat = 1'b0;
  logic [31:0] cyc_q;
  dpe_pkg::dpe_smp_s smp;
  dpe_pkg::dpe_rep_s [1:0] rep;
  dpe_pkg::dpe_rep_s [1:0] last;
  int sum0;
  int sum1;
  int gap;
  int num_errors = 0;
  int checks_done = 0;
  int r50 [6] = '{1, 2, 5, 10, 25, 50};
  int r60 [12] = '{1, 2, 3, 4, 5, 6, 10, 12, 15, 20, 30, 60};
  dpe_row_s rows [12];
  dpe_rej_s rej [10];

  always #2.5 clk = ~clk;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_q <= 32'h0000_0000;
    end else begin
      cyc_q <= cyc_q + 32'h0000_0001;
    end
  end

  dpe_core #(.BATCH_CYCLES(BATCH)) u_dpe_core (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_smp(smp), .o_rep(rep));

  dpe_partner u_dpe_partner (.i_clk(clk), .i_rst(rst), .i_clr(clr), .i_flat(flat),
    .i_rep(rep), .o_smp(smp), .o_last(last), .o_sum0(sum0), .o_sum1(sum1), .o_gap(gap));

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("Error apb ready expected 1 seen %b", pready);
      report_and_stop();
    end
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0000_0000, x, e);
    chk(what, exp, x);
  endtask : rd

  function automatic logic [31:0] mk(input logic f60, input logic [3:0] ri,
      input logic [3:0] wm, input logic [3:0] wn, input logic [1:0] tu, input logic [5:0] sel);
    return {10'h000, sel, wn, wm, ri, tu, f60, 1'b1};
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] x;
    logic e;
    logic [31:0] t0;
    logic [31:0] cur0;
    logic [31:0] cur1;
    for (int k = 0; k < 12; k++) begin
      rows[k].c1 = mk(1'b1, 4'(k), 4'h0, 4'(k % 9), 2'(k % 4), 6'(k * 5 + 1));
      rows[k].s1 = r60[k];
      rows[k].c0 = (k < 6) ? mk(1'b0, 4'(k), 4'h0, 4'((k + 4) % 9), 2'(k), 6'(k * 3 + 2)) : 0;
      rows[k].s0 = (k < 6) ? r50[k] : 0;
    end
    rej = '{'{8'h00, mk(1'b0, 4'h5, 4'h3, 4'h2, 2'h0, 6'h21), 1'b0},
      '{8'h04, mk(1'b1, 4'h9, 4'h3, 4'h3, 2'h1, 6'h3F), 1'b1},
      '{8'h00, mk(1'b0, 4'h5, 4'h3, 4'h2, 2'h0, 6'h21), 1'b1},
      '{8'h04, mk(1'b1, 4'h9, 4'hF, 4'h3, 2'h1, 6'h3F), 1'b0},
      '{8'h04, mk(1'b1, 4'h9, 4'h9, 4'h3, 2'h1, 6'h3F), 1'b1},
      '{8'h04, mk(1'b1, 4'h9, 4'hA, 4'h3, 2'h1, 6'h3F), 1'b0},
      '{8'h04, mk(1'b1, 4'h9, 4'h3, 4'h3, 2'h1, 6'h3F), 1'b1},
      '{8'h00, mk(1'b0, 4'h6, 4'h3, 4'h2, 2'h0, 6'h21), 1'b0},
      '{8'h04, mk(1'b1, 4'hC, 4'h0, 4'h3, 2'h1, 6'h3F), 1'b0},
      '{8'h00, mk(1'b0, 4'h5, 4'h3, 4'h9, 2'h0, 6'h21), 1'b0}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("cfg0 reset", dpe_pkg::A_CFG0, 32'h0000_0000);
    rd("cfg1 reset", dpe_pkg::A_CFG1, 32'h0000_0000);
    rd("id0 reset", dpe_pkg::A_ID0, {16'h0000, dpe_pkg::ID_RST});
    rd("corr reset", dpe_pkg::A_CORR, dpe_pkg::CORR_RST);
    // Rate table rows: every rate code, window type and tuning mode
    foreach (rows[k]) begin
      wr(dpe_pkg::A_CFG0, rows[k].c0);
      wr(dpe_pkg::A_CFG1, rows[k].c1);
      wr(dpe_pkg::A_ID1, 32'(k + 256));
      rd("cfg0", dpe_pkg::A_CFG0, rows[k].c0);
      rd("cfg1", dpe_pkg::A_CFG1, rows[k].c1);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (20 * BATCH) @(posedge clk);
      #1;
      chk("sum0", 32'(rows[k].s0), 32'(sum0));
      chk("sum1", 32'(rows[k].s1), 32'(sum1));
      chk("id1", 32'(k + 256), {16'h0000, last[1].id});
      chk("groups", {29'h0, rows[k].c1[20:18]}, {29'h0, last[1].groups});
      chk("float", {31'h0, rows[k].c1[21]}, {31'h0, last[1].float_fmt});
      @(posedge clk);
    end
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, x, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h02, 32'h0000_0000, x, e);
    chk("unaligned err", 32'h1, {31'h0, e});
    chk("unaligned data", 32'h0000_0000, x);
    // Budget, top-rate and field rejection cases
    cur0 = 32'h0000_0000;
    cur1 = rows[11].c1;
    foreach (rej[j]) begin
      wr(rej[j].a, rej[j].d);
      if (rej[j].ok && rej[j].a == dpe_pkg::A_CFG0) cur0 = rej[j].d;
      if (rej[j].ok && rej[j].a == dpe_pkg::A_CFG1) cur1 = rej[j].d;
      rd("cfg0 kept", dpe_pkg::A_CFG0, cur0);
      rd("cfg1 kept", dpe_pkg::A_CFG1, cur1);
      x = rej[j].ok ? 0 : 32'h1 << (rej[j].a == 0 ? dpe_pkg::ST_REJ0 : dpe_pkg::ST_REJ1);
      rd("reject flag", dpe_pkg::A_STAT, x);
      wr(dpe_pkg::A_STAT, 32'h0000_0300);
    end
    rd("flag clear", dpe_pkg::A_STAT, 32'h0000_0000);
    // 50 Hz W4 beside 60 Hz W4: time tags and batch spacing
    repeat (3 * BATCH) @(posedge clk);
    #1;
    t0 = last[0].tag_us;
    chk("gap", 32'(BATCH), 32'(gap));
    chk("count1", 32'h1, {30'h0, last[1].count});
    chk("tag diff", 4 * (1000000 / 100) - 4 * (1000000 / 120), last[1].tag_us - t0);
    chk("tag age", 32'h1, {31'h0, (cyc_q / 200 - (t0 + 32'd70000)) <= 32'd2});
    repeat (BATCH) @(posedge clk);
    #1;
    chk("tag step", 32'(BATCH / 200), last[0].tag_us - t0);
    // Identical estimators on flat samples, then zero gain
    @(posedge clk);
    flat <= 1'b1;
    wr(dpe_pkg::A_CFG0, mk(1'b0, 4'h3, 4'h1, 4'h2, 2'h0, 6'h01));
    wr(dpe_pkg::A_CFG1, mk(1'b0, 4'h3, 4'h1, 4'h2, 2'h0, 6'h01));
    repeat (8 * BATCH) @(posedge clk);
    #1;
    chk("same value", last[0].value[31:0], last[1].value[31:0]);
    @(posedge clk);
    wr(dpe_pkg::A_CORR, 32'h0000_0000);
    rd("corr", dpe_pkg::A_CORR, 32'h0000_0000);
    repeat (8 * BATCH) @(posedge clk);
    #1;
    chk("zero gain", 32'h0000_0000, last[0].value[31:0]);
    report_and_stop();
  end
endmodule : dual_phasor_estimator_test
